// File: iwd_classify.sv
`timescale 1ns/10ps
`default_nettype none
module iwd_classify (
  iwd_dec_if.cls d
);

  // ------------------------------------------------------------
  // opcode classification
  // ------------------------------------------------------------
  always_comb begin
    d.op = iwd_pkg::OP_OTHER;
    priority casez (d.word)
      16'b1111_????_????_????: d.op = iwd_pkg::OP_NOP;
      16'h0000:                d.op = iwd_pkg::OP_NOP;
      16'h0003:                d.op = iwd_pkg::OP_STANDBY;
      16'h0004:                d.op = iwd_pkg::OP_WATCHDOG_CLEAR;
      16'h0005:                d.op = iwd_pkg::OP_STACK_PUSH;
      16'h0006:                d.op = iwd_pkg::OP_STACK_POP;
      16'h00FF:                d.op = iwd_pkg::OP_SOFT_RESET;
      16'b0000_0000_0000_10??: d.op = iwd_pkg::OP_TABLE_READ;
      16'b0000_0000_0000_11??: d.op = iwd_pkg::OP_TABLE_WRITE;
      16'b0000_0000_0001_000?: d.op = iwd_pkg::OP_INTERRUPT_RETURN;
      16'b0000_0000_0001_001?: d.op = iwd_pkg::OP_RETURN;
      16'b0000_0001_0000_????: d.op = iwd_pkg::OP_BANK_LITERAL_LOAD;
      16'b0000_1111_????_????: d.op = iwd_pkg::OP_ADD_LITERAL;
      16'b0000_1011_????_????: d.op = iwd_pkg::OP_AND_LITERAL;
      16'b0000_1001_????_????: d.op = iwd_pkg::OP_OR_LITERAL;
      16'b0000_1110_????_????: d.op = iwd_pkg::OP_LOAD_LITERAL;
      16'b0000_1101_????_????: d.op = iwd_pkg::OP_MUL_LITERAL;
      16'b0000_1000_????_????: d.op = iwd_pkg::OP_SUB_LITERAL;
      16'b0000_1010_????_????: d.op = iwd_pkg::OP_XOR_LITERAL;
      16'b0000_1100_????_????: d.op = iwd_pkg::OP_RETURN_LITERAL;
      16'b0101_11??_????_????: d.op = iwd_pkg::OP_SUB_ACC_FROM_REG;
      16'b0101_10??_????_????: d.op = iwd_pkg::OP_SUB_ACC_BORROW;
      16'b0011_10??_????_????: d.op = iwd_pkg::OP_NIBBLE_SWAP;
      16'b0001_10??_????_????: d.op = iwd_pkg::OP_XOR_REG;
      16'b1001_????_????_????: d.op = iwd_pkg::OP_BIT_CLEAR;
      16'b1000_????_????_????: d.op = iwd_pkg::OP_BIT_SET;
      16'b1011_????_????_????: d.op = iwd_pkg::OP_BIT_TEST_SKIP_CLEAR;
      16'b1010_????_????_????: d.op = iwd_pkg::OP_BIT_TEST_SKIP_SET;
      16'b0111_????_????_????: d.op = iwd_pkg::OP_BIT_TOGGLE;
      16'b1110_0???_????_????: d.op = iwd_pkg::OP_BRANCH_COND;
      16'b1101_0???_????_????: d.op = iwd_pkg::OP_BRANCH_ALWAYS;
      16'b1101_1???_????_????: d.op = iwd_pkg::OP_RELATIVE_CALL;
      16'b1110_110?_????_????: d.op = iwd_pkg::OP_ABS_CALL;
      16'b1110_1111_????_????: d.op = iwd_pkg::OP_ABSOLUTE_JUMP;
      16'b1110_1110_00??_????: d.op = iwd_pkg::OP_POINTER_LITERAL_LOAD;
      default:                 d.op = iwd_pkg::OP_OTHER;
    endcase
  end

  // ------------------------------------------------------------
  // group attributes
  // ------------------------------------------------------------
  always_comb begin
    d.two_word  = (d.op == iwd_pkg::OP_ABS_CALL) || (d.op == iwd_pkg::OP_ABSOLUTE_JUMP) ||
                  (d.op == iwd_pkg::OP_POINTER_LITERAL_LOAD);
    d.pc_change = (d.op == iwd_pkg::OP_BRANCH_ALWAYS) || (d.op == iwd_pkg::OP_RELATIVE_CALL) ||
                  (d.op == iwd_pkg::OP_INTERRUPT_RETURN) || (d.op == iwd_pkg::OP_RETURN) ||
                  (d.op == iwd_pkg::OP_RETURN_LITERAL);
    d.cond_br   = (d.op == iwd_pkg::OP_BRANCH_COND);
    // bit clear, set and toggle always rewrite f; byte ops only with the destination bit set
    d.wr_reg    = (d.op == iwd_pkg::OP_BIT_CLEAR) || (d.op == iwd_pkg::OP_BIT_SET) ||
                  (d.op == iwd_pkg::OP_BIT_TOGGLE) ||
                  (d.word[9] && ((d.op == iwd_pkg::OP_SUB_ACC_FROM_REG) ||
                  (d.op == iwd_pkg::OP_SUB_ACC_BORROW) || (d.op == iwd_pkg::OP_NIBBLE_SWAP) ||
                  (d.op == iwd_pkg::OP_XOR_REG)));
  end

endmodule
`default_nettype wire

// File: iwd_dec_if.sv
`timescale 1ns/10ps
`default_nettype none
interface iwd_dec_if;
  logic [15:0]      word;
  iwd_pkg::iwd_op_e op;
  logic             two_word;
  logic             pc_change;
  logic             cond_br;
  logic             wr_reg;

  modport cls (input word, output op, two_word, pc_change, cond_br, wr_reg);
  modport usr (output word, input op, two_word, pc_change, cond_br, wr_reg);
endinterface
`default_nettype wire

// File: iwd_mem.sv
`timescale 1ns/10ps
`default_nettype none
// --------
// program memory
// --------
module iwd_mem (
  input  wire logic        pclk,
  input  wire logic        stall,
  input  wire logic        fetch_ready,
  output logic      [15:0] fetch_word,
  output logic             fetch_valid
);
  logic [15:0] q[$];
  initial begin
    fetch_word = 16'h0000;
    fetch_valid = 1'b0;
  end
  task automatic put(input logic [15:0] w);
    q.push_back(w);
  endtask
  // an offered word stands until taken; a withheld word shows its inverse so a stale word never passes as valid
  always @(posedge pclk) begin
    if (fetch_ready === 1'b1 && fetch_valid) void'(q.pop_front());
    if (fetch_ready === 1'b1 || !fetch_valid) begin
      fetch_valid <= q.size() != 0 && !stall;
      fetch_word <= (q.size() != 0 && !stall) ? q[0] : ~fetch_word;
    end
  end
endmodule
`default_nettype wire

// File: iwd_pkg.sv
`default_nettype none
package iwd_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned OSC_PER_ICYC = 4;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_TMR    = 8'h04;
  localparam logic [7:0] A_PLO    = 8'h08;
  localparam logic [7:0] A_PHI    = 8'h0C;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_CNT    = 8'h14;

  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PSA_BIT = 1;
  localparam logic [1:0]  CTRL_RST     = 2'h1;
  localparam logic [11:0] TMR_RST      = 12'h0F0;
  localparam logic [11:0] PLO_RST      = 12'h080;
  localparam logic [11:0] PHI_RST      = 12'h08F;
  localparam logic [3:0]  BANK_RST     = 4'h0;
  localparam logic        TO_RST       = 1'b1;
  localparam logic        PD_RST       = 1'b1;

  // ------------------------------------------------------------
  // access bank split and branch conditions
  // ------------------------------------------------------------
  localparam logic [7:0] ACC_SPLIT   = 8'h60;
  localparam logic [3:0] ACC_HI_BANK = 4'hF;
  localparam logic [1:0] COND_ZERO   = 2'h0;
  localparam logic [1:0] COND_CARRY  = 2'h1;
  localparam logic [1:0] COND_OVF    = 2'h2;
  localparam logic [1:0] COND_NEG    = 2'h3;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'b001,
    ST_SECOND = 3'b010,
    ST_NOP    = 3'b100
  } iwd_st_e;

  typedef enum logic [5:0] {
    OP_NOP, OP_OTHER, OP_SUB_ACC_FROM_REG, OP_SUB_ACC_BORROW, OP_NIBBLE_SWAP,
    OP_XOR_REG, OP_BIT_CLEAR, OP_BIT_SET, OP_BIT_TEST_SKIP_CLEAR,
    OP_BIT_TEST_SKIP_SET, OP_BIT_TOGGLE, OP_BRANCH_COND, OP_BRANCH_ALWAYS,
    OP_RELATIVE_CALL, OP_ABS_CALL, OP_ABSOLUTE_JUMP, OP_INTERRUPT_RETURN,
    OP_RETURN, OP_STANDBY, OP_WATCHDOG_CLEAR, OP_STACK_POP, OP_STACK_PUSH,
    OP_SOFT_RESET, OP_ADD_LITERAL, OP_AND_LITERAL, OP_OR_LITERAL,
    OP_LOAD_LITERAL, OP_MUL_LITERAL, OP_SUB_LITERAL, OP_XOR_LITERAL,
    OP_RETURN_LITERAL, OP_POINTER_LITERAL_LOAD, OP_BANK_LITERAL_LOAD,
    OP_TABLE_READ, OP_TABLE_WRITE
  } iwd_op_e;

endpackage
`default_nettype wire

// File: iwd_top.sv
// Operation
// - port read-modify-write takes source value from the pins, not the latch
// - writing first timer count register clears its prescaler when assigned
// - program-counter change or true test adds one no-operation cycle
// - second word is an operand; a lone 1111 word is a no-operation
// - conditional branches 1110 0ccc with 8-bit offset; one cycle, two if taken
// - absolute call 1110 110s plus 1111 word; two cycles; s selects shadow save
// - absolute jump 1110 1111 plus 1111 word; two cycles
// - bit ops clear, set, skip-clear, skip-set, toggle; skips cost extra cycles
// - interrupt return and return decode; two cycles; irq enables updated
// - standby and watchdog clear take one cycle and set timeout; standby clears powerdown, watchdog clear sets it
// - stack pop, push and software reset words take one cycle
// - literal ops under 0000; return-with-literal takes two cycles
// - pointer literal load is two words, two cycles, 12-bit literal
// - bank literal load writes four bits into the bank select register
// - table read 10mm, write 11mm; two cycles; mm selects pointer change
// - subtract, subtract with borrow, nibble swap, xor byte op encodings
// - one instruction cycle is four oscillator periods
// - destination bit 0 targets accumulator, 1 targets the register
// - access bit 0 uses access bank, 1 uses bank select register
//
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module iwd_top #(
  parameter int unsigned AW = 8
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [AW-1:0] paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  input  wire logic [15:0]   fetch_word,
  input  wire logic          fetch_valid,
  output logic               fetch_ready,
  input  wire logic          flag_zero,
  input  wire logic          flag_carry,
  input  wire logic          overflow_flag,
  input  wire logic          flag_neg,
  input  wire logic          tested_bit,
  output logic               op_valid,
  output logic      [5:0]    op_kind,
  output logic      [19:0]   op_literal,
  output logic      [11:0]   op_addr,
  output logic      [2:0]    op_bit,
  output logic               op_dest_reg,
  output logic               op_fast,
  output logic      [1:0]    op_ptr_sel,
  output logic      [1:0]    op_tbl_mode,
  output logic               op_src_pins,
  output logic               prescaler_clr,
  output logic               irq_enable_load,
  output logic               timeout_flag,
  output logic               powerdown_flag,
  output logic      [3:0]    bank_select_register
);

  // ------------------------------------------------------------
  // instruction cycle divider
  // ------------------------------------------------------------
  logic [1:0] div_r;
  logic       tick;

  assign tick = (div_r == 2'(iwd_pkg::OSC_PER_ICYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 2'h0;
    end else begin
      div_r <= tick ? 2'h0 : div_r + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [1:0]  ctrl_r;
  logic [11:0] tmr_r;
  logic [11:0] plo_r;
  logic [11:0] phi_r;
  logic [15:0] cnt_r;
  logic        wr_acc;
  logic        mapped;
  logic [31:0] rd_nxt;
  iwd_pkg::iwd_st_e state_r;
  logic        skip_r;

  assign mapped  = (paddr == AW'(iwd_pkg::A_CTRL)) || (paddr == AW'(iwd_pkg::A_TMR)) ||
                   (paddr == AW'(iwd_pkg::A_PLO)) || (paddr == AW'(iwd_pkg::A_PHI)) ||
                   (paddr == AW'(iwd_pkg::A_STAT)) || (paddr == AW'(iwd_pkg::A_CNT));
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_acc  = psel && penable && pwrite && mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= iwd_pkg::CTRL_RST;
      tmr_r  <= iwd_pkg::TMR_RST;
      plo_r  <= iwd_pkg::PLO_RST;
      phi_r  <= iwd_pkg::PHI_RST;
    end else if (wr_acc) begin
      if (paddr == AW'(iwd_pkg::A_CTRL)) ctrl_r <= pwdata[1:0];
      if (paddr == AW'(iwd_pkg::A_TMR))  tmr_r  <= pwdata[11:0];
      if (paddr == AW'(iwd_pkg::A_PLO))  plo_r  <= pwdata[11:0];
      if (paddr == AW'(iwd_pkg::A_PHI))  phi_r  <= pwdata[11:0];
    end
  end

  always_comb begin
    rd_nxt = 32'h0;
    if (paddr == AW'(iwd_pkg::A_CTRL)) rd_nxt = {30'h0, ctrl_r};
    if (paddr == AW'(iwd_pkg::A_TMR))  rd_nxt = {20'h0, tmr_r};
    if (paddr == AW'(iwd_pkg::A_PLO))  rd_nxt = {20'h0, plo_r};
    if (paddr == AW'(iwd_pkg::A_PHI))  rd_nxt = {20'h0, phi_r};
    if (paddr == AW'(iwd_pkg::A_STAT)) begin
      rd_nxt = {22'h0, skip_r, state_r, powerdown_flag, timeout_flag, bank_select_register};
    end
    if (paddr == AW'(iwd_pkg::A_CNT))  rd_nxt = {16'h0, cnt_r};
  end

  // read data is latched in the setup cycle so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rd_nxt;
    end
  end

  // ------------------------------------------------------------
  // classification
  // ------------------------------------------------------------
  iwd_dec_if dec ();

  assign dec.word = fetch_word;

  iwd_classify u_cls (
    .d (dec.cls)
  );

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  logic [15:0] held_r;
  logic        take;
  logic        issue;
  logic        exec;
  logic        cond_base;
  logic        cond_taken;
  logic        skip_hit;
  logic        skip_nxt;
  iwd_pkg::iwd_op_e kind_nxt;
  iwd_pkg::iwd_st_e state_nxt;

  // a no-operation cycle is emitted even while disabled, so a stall never splits it
  assign fetch_ready = tick && ctrl_r[iwd_pkg::CTRL_EN_BIT] && (state_r != iwd_pkg::ST_NOP);
  assign take        = fetch_ready && fetch_valid;

  always_comb begin
    unique case (fetch_word[10:9])
      iwd_pkg::COND_ZERO:  cond_base = flag_zero;
      iwd_pkg::COND_CARRY: cond_base = flag_carry;
      iwd_pkg::COND_OVF:   cond_base = overflow_flag;
      iwd_pkg::COND_NEG:   cond_base = flag_neg;
    endcase
    cond_taken = cond_base ^ fetch_word[8];
    skip_hit   = ((dec.op == iwd_pkg::OP_BIT_TEST_SKIP_CLEAR) && !tested_bit) ||
                 ((dec.op == iwd_pkg::OP_BIT_TEST_SKIP_SET) && tested_bit);
  end

  always_comb begin
    issue     = 1'b0;
    exec      = 1'b0;
    kind_nxt  = iwd_pkg::OP_NOP;
    state_nxt = state_r;
    skip_nxt  = skip_r;
    unique case (state_r)
      iwd_pkg::ST_NOP: begin
        if (tick) begin
          issue     = 1'b1;
          state_nxt = iwd_pkg::ST_FETCH;
        end
      end
      iwd_pkg::ST_SECOND: begin
        if (take) begin
          issue     = 1'b1;
          kind_nxt  = iwd_pkg::iwd_op_e'(op_kind_hold(held_r));
          state_nxt = iwd_pkg::ST_FETCH;
        end
      end
      iwd_pkg::ST_FETCH: begin
        if (take) begin
          if (skip_r) begin
            issue    = 1'b1;
            skip_nxt = 1'b0;
          end else if (dec.two_word) begin
            state_nxt = iwd_pkg::ST_SECOND;
          end else begin
            issue    = 1'b1;
            exec     = 1'b1;
            kind_nxt = dec.op;
            // table transfers also cost a second, idle instruction cycle
            if (dec.pc_change || (dec.cond_br && cond_taken) ||
                dec.op == iwd_pkg::OP_TABLE_READ || dec.op == iwd_pkg::OP_TABLE_WRITE) begin
              state_nxt = iwd_pkg::ST_NOP;
            end
            if (skip_hit) begin
              skip_nxt = 1'b1;
            end
          end
        end
      end
      default: begin
        state_nxt = iwd_pkg::ST_FETCH;
      end
    endcase
  end

  function automatic logic [5:0] op_kind_hold(input logic [15:0] w);
    logic [5:0] k;
    k = 6'(iwd_pkg::OP_POINTER_LITERAL_LOAD);
    if (w[11:9] == 3'b110) k = 6'(iwd_pkg::OP_ABS_CALL);
    if (w[11:8] == 4'hF)   k = 6'(iwd_pkg::OP_ABSOLUTE_JUMP);
    return k;
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= iwd_pkg::ST_FETCH;
      skip_r  <= 1'b0;
      held_r  <= 16'h0;
      cnt_r   <= 16'h0;
    end else begin
      state_r <= state_nxt;
      skip_r  <= skip_nxt;
      if (take && state_r == iwd_pkg::ST_FETCH) held_r <= fetch_word;
      if (issue) cnt_r <= cnt_r + 16'h1;
    end
  end

  // ------------------------------------------------------------
  // operand fields
  // ------------------------------------------------------------
  logic [11:0] addr_nxt;
  logic        in_port;

  always_comb begin
    if (fetch_word[8]) begin
      addr_nxt = {bank_select_register, fetch_word[7:0]};
    end else if (fetch_word[7:0] < iwd_pkg::ACC_SPLIT) begin
      addr_nxt = {4'h0, fetch_word[7:0]};
    end else begin
      addr_nxt = {iwd_pkg::ACC_HI_BANK, fetch_word[7:0]};
    end
    in_port = (addr_nxt >= plo_r) && (addr_nxt <= phi_r);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_valid    <= 1'b0;
      op_kind     <= 6'h0;
      op_literal  <= 20'h0;
      op_addr     <= 12'h0;
      op_bit      <= 3'h0;
      op_dest_reg <= 1'b0;
      op_fast     <= 1'b0;
      op_ptr_sel  <= 2'h0;
      op_tbl_mode <= 2'h0;
    end else begin
      op_valid <= issue;
      if (issue) begin
        op_kind     <= 6'(kind_nxt);
        op_addr     <= addr_nxt;
        op_bit      <= fetch_word[11:9];
        op_dest_reg <= fetch_word[9];
        op_fast     <= fetch_word[0];
        op_tbl_mode <= fetch_word[1:0];
        op_ptr_sel  <= 2'h0;
        op_literal  <= {12'h0, fetch_word[7:0]};
        if (kind_nxt == iwd_pkg::OP_BRANCH_ALWAYS || kind_nxt == iwd_pkg::OP_RELATIVE_CALL) begin
          op_literal <= {9'h0, fetch_word[10:0]};
        end
        if (state_r == iwd_pkg::ST_SECOND) begin
          op_literal <= {fetch_word[11:0], held_r[7:0]};
          op_fast    <= held_r[8];
          op_ptr_sel <= held_r[5:4];
          if (kind_nxt == iwd_pkg::OP_POINTER_LITERAL_LOAD) begin
            op_literal <= {8'h0, held_r[3:0], fetch_word[7:0]};
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // side effects
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_src_pins     <= 1'b0;
      prescaler_clr   <= 1'b0;
      irq_enable_load <= 1'b0;
    end else begin
      op_src_pins     <= exec && dec.wr_reg && in_port;
      prescaler_clr   <= exec && dec.wr_reg && (addr_nxt == tmr_r) &&
                         ctrl_r[iwd_pkg::CTRL_PSA_BIT];
      irq_enable_load <= exec && (dec.op == iwd_pkg::OP_INTERRUPT_RETURN);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_register <= iwd_pkg::BANK_RST;
    end else if (exec && dec.op == iwd_pkg::OP_BANK_LITERAL_LOAD) begin
      bank_select_register <= fetch_word[3:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timeout_flag   <= iwd_pkg::TO_RST;
      powerdown_flag <= iwd_pkg::PD_RST;
    end else if (exec && dec.op == iwd_pkg::OP_STANDBY) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (exec && dec.op == iwd_pkg::OP_WATCHDOG_CLEAR) begin
      timeout_flag   <= 1'b1;
      powerdown_flag <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_ICYC_FOUR: assert property (tick |=> (!tick)[*3] ##1 tick)
    else $error("instruction cycle not four clocks");
  AST_PC_NOP: assert property (op_valid && op_kind == 6'(iwd_pkg::OP_BRANCH_ALWAYS)
    |-> ##4 (op_valid && op_kind == 6'(iwd_pkg::OP_NOP)))
    else $error("no idle cycle after program counter change");
  AST_LONE_SECOND: assert property (take && state_r == iwd_pkg::ST_FETCH && !skip_r &&
    fetch_word[15:12] == 4'hF |=> op_valid && op_kind == 6'(iwd_pkg::OP_NOP))
    else $error("lone second word not a no-operation");
  AST_HOLD_FIRST: assert property (take && state_r == iwd_pkg::ST_FETCH && !skip_r &&
    dec.two_word |=> !op_valid && state_r == iwd_pkg::ST_SECOND)
    else $error("first word issued alone");
  AST_BANK_LOAD: assert property (op_valid && op_kind == 6'(iwd_pkg::OP_BANK_LITERAL_LOAD)
    |-> bank_select_register == op_literal[3:0])
    else $error("bank select not loaded");
  AST_STANDBY_FLAGS: assert property (op_valid && op_kind == 6'(iwd_pkg::OP_STANDBY)
    |-> timeout_flag && !powerdown_flag)
    else $error("standby flags wrong");
  AST_WDT_FLAGS: assert property (op_valid && op_kind == 6'(iwd_pkg::OP_WATCHDOG_CLEAR)
    |-> timeout_flag && powerdown_flag)
    else $error("watchdog clear flags wrong");
  AST_PRESCALER: assert property (prescaler_clr |-> op_valid && op_addr == tmr_r &&
    $past(ctrl_r[iwd_pkg::CTRL_PSA_BIT]))
    else $error("prescaler clear without cause");
  AST_CALL_LIT: assert property (op_valid && op_kind == 6'(iwd_pkg::OP_ABS_CALL)
    |-> op_literal[7:0] == held_r[7:0] && op_fast == held_r[8])
    else $error("call address or fast bit wrong");

  COV_CALL: cover property (op_valid && op_kind == 6'(iwd_pkg::OP_ABS_CALL));
  COV_SKIP: cover property (skip_r && take);
  COV_BRANCH_TAKEN: cover property (state_r == iwd_pkg::ST_NOP && op_valid &&
    op_kind == 6'(iwd_pkg::OP_BRANCH_COND));

endmodule
`default_nettype wire

// File: iwd_top_bench.sv
`timescale 1ns/10ps
`default_nettype none
module iwd_top_bench;
  // --------
  // stimulus and checking
  // --------
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0, er;
  logic [7:0]  paddr = 8'h00, r8;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, fetch_valid, fetch_ready, op_valid, op_src_pins, prescaler_clr, irq_enable_load;
  logic        op_dest_reg;
  logic [1:0]  op_tbl_mode;
  logic [11:0] op_addr;
  logic [15:0] fetch_word;
  logic [4:0]  fl = 5'h00;
  logic [5:0]  op_kind;
  logic [19:0] op_literal;
  logic [3:0]  bank_select_register;
  logic [3:0]  ln[8] = '{4'hF, 4'hB, 4'h9, 4'hE, 4'hD, 4'h8, 4'hA, 4'hC};
  logic [47:0] e, exp_q[$];
  integer      seed = 32'hCD46, fails = 0, comparisons = 0, n, c;
  iwd_pkg::iwd_op_e lk[8] = '{iwd_pkg::OP_ADD_LITERAL, iwd_pkg::OP_AND_LITERAL, iwd_pkg::OP_OR_LITERAL,
    iwd_pkg::OP_LOAD_LITERAL, iwd_pkg::OP_MUL_LITERAL, iwd_pkg::OP_SUB_LITERAL, iwd_pkg::OP_XOR_LITERAL,
    iwd_pkg::OP_RETURN_LITERAL};
  always #5 pclk = ~pclk;
  always @(posedge pclk) stall <= 1'($random(seed));
  iwd_mem i_iwd_mem (.pclk, .stall, .fetch_ready, .fetch_word, .fetch_valid);
  iwd_top i_iwd_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .fetch_word, .fetch_valid, .fetch_ready, .flag_zero(fl[0]), .flag_carry(fl[1]), .overflow_flag(fl[2]),
    .flag_neg(fl[3]), .tested_bit(fl[4]), .op_valid, .op_kind, .op_literal, .op_addr, .op_bit(),
    .op_dest_reg, .op_fast(), .op_ptr_sel(), .op_tbl_mode, .op_src_pins, .prescaler_clr,
    .irq_enable_load, .timeout_flag(), .powerdown_flag(), .bank_select_register);
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    comparisons++;
    if (got !== want) begin
      fails++;
      $display("Error at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (pready !== 1'b1) begin
      fails++;
      $display("Error at %0t: bus timeout", $time);
      end_of_test();
    end
  endtask
  // expected side flags s are {prescaler clear, pin source}; only literal bits under m are compared
  task automatic op(input logic [15:0] wd, input iwd_pkg::iwd_op_e k, input int nops, input logic [1:0] s,
                    input logic [19:0] m, input logic [19:0] l);
    i_iwd_mem.put(wd);
    exp_q.push_back({6'(k), s, m, l});
    repeat (nops) exp_q.push_back({6'(iwd_pkg::OP_NOP), 42'h0});
  endtask
  always @(posedge pclk) begin
    if (op_valid === 1'b1) begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 48'hFFFF_FFFF_FFFF;
      cmp({26'h0, op_kind}, {26'h0, e[47:42]});
      cmp({30'h0, prescaler_clr, op_src_pins}, {30'h0, e[41:40]});
      cmp({12'h0, op_literal & e[39:20]}, {12'h0, e[19:0]});
      cmp({31'h0, irq_enable_load}, {31'h0, e[47:42] == 6'(iwd_pkg::OP_INTERRUPT_RETURN)});
      if (e[47:42] == 6'(iwd_pkg::OP_TABLE_READ) || e[47:42] == 6'(iwd_pkg::OP_TABLE_WRITE))
        cmp({30'h0, op_tbl_mode}, {30'h0, e[1:0]});
      if (e[47:42] >= 6'(iwd_pkg::OP_SUB_ACC_FROM_REG) && e[47:42] <= 6'(iwd_pkg::OP_XOR_REG))
        cmp({19'h0, op_dest_reg, op_addr}, {20'h1, 12'h010});
    end
  end
  task automatic end_of_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    @(posedge pclk);
    fl <= 5'($random(seed));
    repeat (7) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, iwd_pkg::A_CTRL, 32'h0);
    cmp(rd, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    apb(1'b1, iwd_pkg::A_TMR, 32'hFF0);
    apb(1'b1, iwd_pkg::A_CTRL, 32'h3);
    apb(1'b1, iwd_pkg::A_PLO, 32'hF80);
    apb(1'b1, iwd_pkg::A_PHI, 32'hF8F);
    apb(1'b0, iwd_pkg::A_TMR, 32'h0);
    cmp(rd, 32'hFF0);
    $display("register test done");
    op(16'h8EF0, iwd_pkg::OP_BIT_SET, 0, 2'b10, 20'h0, 20'h0);
    op(16'h9E85, iwd_pkg::OP_BIT_CLEAR, 0, 2'b01, 20'h0, 20'h0);
    op(16'h7E10, iwd_pkg::OP_BIT_TOGGLE, 0, 2'b00, 20'h0, 20'h0);
    op(16'hB010, iwd_pkg::OP_BIT_TEST_SKIP_CLEAR, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0F00, fl[4] ? iwd_pkg::OP_ADD_LITERAL : iwd_pkg::OP_NOP, 0, 2'b00, 20'h0, 20'h0);
    op(16'hA010, iwd_pkg::OP_BIT_TEST_SKIP_SET, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0F00, fl[4] ? iwd_pkg::OP_NOP : iwd_pkg::OP_ADD_LITERAL, 0, 2'b00, 20'h0, 20'h0);
    for (c = 0; c < 8; c++) begin
      r8 = 8'($random(seed));
      op({4'h0, ln[c], r8}, lk[c], c == 7, 2'b00, 20'hFF, {12'h0, r8});
      op(16'hE005 | 16'(c << 8), iwd_pkg::OP_BRANCH_COND, fl[c / 2] ^ c[0], 2'b00, 20'h7FF, 20'h5);
      op(16'h0008 + 16'(c), c < 4 ? iwd_pkg::OP_TABLE_READ : iwd_pkg::OP_TABLE_WRITE, 1, 2'b00, 20'h3, 20'(c % 4));
    end
    op(16'hD005, iwd_pkg::OP_BRANCH_ALWAYS, 1, 2'b00, 20'h7FF, 20'h5);
    op(16'hD805, iwd_pkg::OP_RELATIVE_CALL, 1, 2'b00, 20'h0, 20'h0);
    op(16'h0011, iwd_pkg::OP_INTERRUPT_RETURN, 1, 2'b00, 20'h0, 20'h0);
    op(16'h0012, iwd_pkg::OP_RETURN, 1, 2'b00, 20'h0, 20'h0);
    op(16'h0003, iwd_pkg::OP_STANDBY, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0004, iwd_pkg::OP_WATCHDOG_CLEAR, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0006, iwd_pkg::OP_STACK_POP, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0005, iwd_pkg::OP_STACK_PUSH, 0, 2'b00, 20'h0, 20'h0);
    op(16'h00FF, iwd_pkg::OP_SOFT_RESET, 0, 2'b00, 20'h0, 20'h0);
    i_iwd_mem.put(16'hEF12);
    op(16'hF345, iwd_pkg::OP_ABSOLUTE_JUMP, 0, 2'b00, 20'hFFFFF, 20'h34512);
    i_iwd_mem.put(16'hED34);
    op(16'hF012, iwd_pkg::OP_ABS_CALL, 0, 2'b00, 20'hFFFFF, 20'h01234);
    i_iwd_mem.put(16'hEE1A);
    op(16'hF0BC, iwd_pkg::OP_POINTER_LITERAL_LOAD, 0, 2'b00, 20'hFFF, 20'hABC);
    op(16'hF123, iwd_pkg::OP_NOP, 0, 2'b00, 20'h0, 20'h0);
    op(16'h5E10, iwd_pkg::OP_SUB_ACC_FROM_REG, 0, 2'b00, 20'h0, 20'h0);
    op(16'h5A10, iwd_pkg::OP_SUB_ACC_BORROW, 0, 2'b00, 20'h0, 20'h0);
    op(16'h3A10, iwd_pkg::OP_NIBBLE_SWAP, 0, 2'b00, 20'h0, 20'h0);
    op(16'h1A10, iwd_pkg::OP_XOR_REG, 0, 2'b00, 20'h0, 20'h0);
    op(16'h0105, iwd_pkg::OP_BANK_LITERAL_LOAD, 0, 2'b00, 20'h0, 20'h0);
    for (n = 0; n < 3000 && exp_q.size() != 0; n++) @(posedge pclk);
    repeat (8) @(posedge pclk);
    if (exp_q.size() != 0) begin
      fails++;
      $display("Error at %0t: ops missing", $time);
    end
    cmp({28'h0, bank_select_register}, 32'h5);
    $display("decode test done");
    end_of_test();
  end
endmodule
`default_nettype wire
